// [rtl/nxu_core.sv]
// nxu_core: executes the exchange-digit and exclusive-or instructions
// assumes one instruction beat per cycle; direct,#data comes as two beats
`timescale 1ns/10ps
`default_nettype none

// Function
// - swap accumulator low nibble with pointed RAM
// - high nibbles of both stay unchanged
// - exchange-digit leaves status flags alone
// - xor destination with source, store in destination
// - xor leaves status flags alone
// - accumulator destination: register, direct, indirect, immediate
// - direct destination: accumulator or immediate only
// - port destination reads latch, not pins
// - accumulator-direct xor is two bytes, one cycle
module nxu_core
  import nxu_pkg::*;
(
  // clock and reset
  input  wire logic           clk_sys,
  input  wire logic           srst,
  // instruction from sequencer
  input  wire nxu_instr_type  instr,
  // program status word, owned elsewhere
  input  wire logic [7:0]     psw_in,
  // port pins
  input  wire logic [7:0]     port1_pins,
  // results
  output logic [7:0]          acc,
  output logic [7:0]          port1_latch,
  output logic [7:0]          psw_out,
  output nxu_status_type      status
);

  logic [7:0] ram [RAM_DEPTH];
  logic [7:0] next_acc;
  logic [7:0] next_port1_latch;
  logic [7:0] next_psw_out;
  nxu_status_type next_status;
  logic       ram_we;
  logic [6:0] ram_waddr;
  logic [7:0] ram_wdata;

  logic [1:0] bank;
  logic [4:0] bank_base;
  logic [7:0] ptr_val;
  logic [7:0] reg_val;
  logic [7:0] ind_val;
  logic [7:0] dir_val;
  logic [7:0] opc;
  logic [7:0] opnd;

  // direct,#data arrives as two beats of the same opcode
  typedef enum {
    SEQ_IDLE,
    SEQ_WAIT_DATA
  } nxu_seq_state_type;

  nxu_seq_state_type seq_state;
  nxu_seq_state_type next_seq_state;
  logic [7:0]        pend_addr;
  logic [7:0]        next_pend_addr;

  // decoded instruction class
  nxu_acc_op_type    op_class;
  logic              is_digit;
  logic              is_xor_reg;
  logic              is_xor_dir;
  logic              is_xor_ind;
  logic              is_xor_imm;
  logic              is_xor_dst_acc;
  logic              is_xor_dst_imm;
  logic              take_data;
  logic [7:0]        dst_old;

  assign opc       = instr.opcode;
  assign opnd      = instr.operand;
  assign bank      = psw_in[BANK_SEL_LSB +: 2];
  assign bank_base = {bank, 3'h0};
  assign ptr_val   = ram[{2'h0, bank_base + {4'h0, opc[0]}}];
  assign reg_val   = ram[{2'h0, bank_base + {2'h0, opc[2:0]}}];
  assign ind_val   = ram[ptr_val[6:0]];

  // direct reads: port returns its latch, never the pins
  always_comb
  begin
    if (opnd == PORT1_ADDR)
      dir_val = port1_latch;
    else if (opnd >= SFR_BASE)
      dir_val = 8'h00;
    else
      dir_val = ram[opnd[6:0]];
  end

  // opcode decode; low bits that pick a pointer or register are masked off
  always_comb
  begin
    is_digit       = (opc & MASK_PTR_SEL) == OPC_EXCH_DIGIT;
    is_xor_reg     = (opc & MASK_REG_SEL) == OPC_XOR_A_REG;
    is_xor_dir     = opc == OPC_XOR_A_DIR;
    is_xor_ind     = (opc & MASK_PTR_SEL) == OPC_XOR_A_IND;
    is_xor_imm     = opc == OPC_XOR_A_IMM;
    is_xor_dst_acc = opc == OPC_XOR_D_A;
    is_xor_dst_imm = opc == OPC_XOR_D_IMM;
    if (is_digit)
      op_class = ACC_OP_EXCH_DIGIT;
    else if (is_xor_reg || is_xor_dir || is_xor_ind || is_xor_imm || is_xor_dst_acc
             || is_xor_dst_imm)
      op_class = ACC_OP_XOR;
    else
      op_class = ACC_OP_NONE;
  end

  // mask beat of direct,#data while an address beat is pending
  assign take_data = instr.valid && (seq_state == SEQ_WAIT_DATA) && is_xor_dst_imm;

  // old value of the pending destination: port latch, never the pins
  always_comb
  begin
    if (pend_addr == PORT1_ADDR)
      dst_old = port1_latch;
    else if (pend_addr >= SFR_BASE)
      dst_old = 8'h00;
    else
      dst_old = ram[pend_addr[6:0]];
  end

  always_comb
  begin
    next_acc         = acc;
    next_port1_latch = port1_latch;
    next_psw_out     = psw_in;
    next_status      = '0;
    next_seq_state   = seq_state;
    next_pend_addr   = pend_addr;
    ram_we           = 1'b0;
    ram_waddr        = 7'h00;
    ram_wdata        = 8'h00;
    if (take_data)
    begin
      // second beat of direct,#data: operand is the mask
      next_status.done = 1'b1;
      next_seq_state   = SEQ_IDLE;
      if (pend_addr == PORT1_ADDR)
        next_port1_latch = port1_latch ^ opnd;
      else if (pend_addr < SFR_BASE)
      begin
        ram_we    = 1'b1;
        ram_waddr = pend_addr[6:0];
        ram_wdata = dst_old ^ opnd;
      end
    end
    else if (instr.valid)
    begin
      // any other opcode drops a pending direct,#data and runs as itself
      next_seq_state   = SEQ_IDLE;
      next_status.done = 1'b1;
      case (op_class)
        ACC_OP_EXCH_DIGIT:
        begin
          next_acc  = {acc[7:4], ind_val[NIB_LO_MSB:0]};
          ram_we    = 1'b1;
          ram_waddr = ptr_val[6:0];
          ram_wdata = {ind_val[7:4], acc[NIB_LO_MSB:0]};
        end
        ACC_OP_XOR:
        begin
          if (is_xor_reg)
            next_acc = acc ^ reg_val;
          else if (is_xor_dir)
            next_acc = acc ^ dir_val;
          else if (is_xor_ind)
            next_acc = acc ^ ind_val;
          else if (is_xor_imm)
            next_acc = acc ^ opnd;
          else if (is_xor_dst_acc)
          begin
            // direct destination: operand is address, mask is accumulator
            if (opnd == PORT1_ADDR)
              next_port1_latch = port1_latch ^ acc;
            else if (opnd < SFR_BASE)
            begin
              ram_we    = 1'b1;
              ram_waddr = opnd[6:0];
              ram_wdata = dir_val ^ acc;
            end
          end
          else
          begin
            // first beat of direct,#data: hold the address for the mask beat
            next_status.done = 1'b0;
            next_seq_state   = SEQ_WAIT_DATA;
            next_pend_addr   = opnd;
          end
        end
        default:
        begin
          next_status.done    = 1'b0;
          next_status.illegal = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      acc         <= ACC_RESET;
      port1_latch <= PORT_RESET;
      psw_out     <= PSW_RESET;
      status      <= '0;
      seq_state   <= SEQ_IDLE;
      pend_addr   <= ADDR_RESET;
    end
    else
    begin
      acc         <= next_acc;
      port1_latch <= next_port1_latch;
      psw_out     <= next_psw_out;
      status      <= next_status;
      seq_state   <= next_seq_state;
      pend_addr   <= next_pend_addr;
    end
  end

  // cleared on reset so pointer reads never return unknowns
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      for (int i = 0; i < RAM_DEPTH; i++)
        ram[i] <= RAM_RESET;
    end
    else if (ram_we)
      ram[ram_waddr] <= ram_wdata;
  end

  logic unused_pins;
  assign unused_pins = ^port1_pins;

endmodule : nxu_core

`default_nettype wire

// [rtl/nxu_pkg.sv]
// nxu_pkg: constants and carrier types for the nibble exchange / xor unit
// assumes one core clock; opcodes and operand bytes arrive already fetched
package nxu_pkg;

  // opcode patterns
  localparam logic [7:0] OPC_EXCH_DIGIT = 8'hd6;  // low bit picks pointer
  localparam logic [7:0] OPC_XOR_A_REG  = 8'h68;  // low three bits pick register
  localparam logic [7:0] OPC_XOR_A_DIR  = 8'h65;
  localparam logic [7:0] OPC_XOR_A_IND  = 8'h66;  // low bit picks pointer
  localparam logic [7:0] OPC_XOR_A_IMM  = 8'h64;
  localparam logic [7:0] OPC_XOR_D_A    = 8'h62;
  localparam logic [7:0] OPC_XOR_D_IMM  = 8'h63;
  localparam logic [7:0] MASK_PTR_SEL   = 8'hfe;
  localparam logic [7:0] MASK_REG_SEL   = 8'hf8;

  // address map pieces, reset values and field positions
  localparam logic [7:0] SFR_BASE       = 8'h80;
  localparam logic [7:0] PORT1_ADDR     = 8'h90;
  localparam logic [7:0] ACC_RESET      = 8'h00;
  localparam logic [7:0] PORT_RESET     = 8'hff;
  localparam logic [7:0] PSW_RESET      = 8'h00;
  localparam logic [7:0] RAM_RESET      = 8'h00;
  localparam logic [7:0] ADDR_RESET     = 8'h00;
  localparam int         RAM_DEPTH      = 128;
  localparam int         NIB_LO_MSB     = 3;
  localparam int         BANK_SEL_LSB   = 3;

  typedef enum logic [1:0] {
    ACC_OP_NONE,
    ACC_OP_EXCH_DIGIT,
    ACC_OP_XOR
  } nxu_acc_op_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] opcode;
    logic [7:0] operand;
  } nxu_instr_type;

  typedef struct packed {
    logic       done;
    logic       illegal;
  } nxu_status_type;

endpackage : nxu_pkg

// [verif/nxu_core_asserts.sv]
// nxu_core_asserts: port checks, bound onto nxu_core below
`timescale 1ns/10ps
`default_nettype none
module nxu_core_asserts import nxu_pkg::*; (
  // watched ports
  input wire logic           clk_sys,
  input wire logic           srst,
  input wire nxu_instr_type  instr,
  input wire logic [7:0]     psw_in,
  input wire logic [7:0]     acc,
  input wire logic [7:0]     port1_latch,
  input wire logic [7:0]     psw_out,
  input wire nxu_status_type status
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  wire logic       v = instr.valid;
  wire logic [7:0] o = instr.opcode;
  wire logic       p = instr.operand == PORT1_ADDR;
  wire logic       d = (o & MASK_PTR_SEL) == OPC_EXCH_DIGIT;
  wire logic [7:0] y = acc ^ port1_latch;
  wire logic [7:0] z = acc ^ instr.operand;
  wire logic [7:0] m = port1_latch ^ instr.operand;
  // direct,#data: open after an address beat, closed by any beat
  logic imm_open;
  logic imm_port;
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      imm_open <= 1'b0;
      imm_port <= 1'b0;
    end
    else if (v)
    begin
      imm_open <= (o == OPC_XOR_D_IMM) && !imm_open;
      imm_port <= p;
    end
  end
  sequence imm_start_s;
    v && o == OPC_XOR_D_IMM && !imm_open;
  endsequence
  sequence imm_data_s;
    v && o == OPC_XOR_D_IMM && imm_open && imm_port;
  endsequence
  acc_imm_a: assert property (v && o == OPC_XOR_A_IMM |=> acc == $past(z) && status.done)
    else $error("immediate xor");
  digit_hi_a: assert property (v && d |=> $stable(acc[7:4]))
    else $error("digit high nibble");
  imm_start_a: assert property (imm_start_s |=> $stable(port1_latch) && !status.done)
    else $error("address beat wrote");
  imm_port_a: assert property (imm_data_s |=> port1_latch == $past(m))
    else $error("mask beat on port");
  psw_ok_a: assert property (!$past(srst) |-> psw_out == $past(psw_in))
    else $error("flags moved");
  port_read_a: assert property (v && o == OPC_XOR_A_DIR && p |=> acc == $past(y))
    else $error("port read");
  latch_xor_a: assert property (v && o == OPC_XOR_D_A && p |=> port1_latch == $past(y))
    else $error("latch xor");
endmodule : nxu_core_asserts
bind nxu_core nxu_core_asserts chk_u (.clk_sys, .srst, .instr, .psw_in, .acc,
  .port1_latch, .psw_out, .status);
`default_nettype wire

// [verif/nxu_core_tb.sv]
// nxu_core_tb: directed checks of nxu_core
// assumes the pin model on port one
`timescale 1ns/10ps
`default_nettype none
module nxu_core_tb import nxu_pkg::*; ();
  logic clk_sys = 1'b0, srst = 1'b1;
  nxu_instr_type instr = '0;
  nxu_status_type status;
  logic [7:0] psw_in = 8'h5a, acc, port1_latch, psw_out;
  wire logic [7:0] port1_pins;
  int err_total = 0, checked = 0;
  always #5 clk_sys = ~clk_sys;
  nxu_core dut_u (.clk_sys, .srst, .instr, .psw_in, .port1_pins, .acc, .port1_latch,
    .psw_out, .status);
  nxu_pins pins_u (.port1_latch, .port1_pins);
  task chk(input logic [7:0] seen, exp);
    checked++;
    err_total += int'(seen !== exp);
    if (seen !== exp) $display("Error %0t seen %h exp %h", $time, seen, exp);
  endtask : chk
  task run(input logic [7:0] op, d);
    @(negedge clk_sys) instr = {1'b1, op, d};
    @(negedge clk_sys) instr.valid = 1'b0;
  endtask : run
  // direct,#data: address beat, then mask beat
  task run_imm(input logic [7:0] addr, mask);
    run(OPC_XOR_D_IMM, addr);
    run(OPC_XOR_D_IMM, mask);
  endtask : run_imm
  task t_acc;
    run(OPC_XOR_A_IMM, 8'h3c);
    chk(acc, 8'h3c);
    run(OPC_XOR_A_DIR, PORT1_ADDR);
    chk(acc, 8'hc3);
  endtask : t_acc
  task t_dest;
    run(OPC_XOR_D_A, PORT1_ADDR);
    chk(port1_latch, 8'h3c);
    run(OPC_XOR_D_IMM, PORT1_ADDR);
    chk(port1_latch, 8'h3c);
    run(OPC_XOR_D_IMM, 8'h31);
    chk(port1_latch, 8'h0d);
    run(8'h00, 8'h00);
    chk({6'h00, status}, 8'h01);
  endtask : t_dest
  task t_digit;
    run_imm(8'h18, 8'h20);
    run_imm(8'h20, 8'h75);
    run(OPC_XOR_A_IMM, 8'hf5);
    chk(acc, 8'h36);
    run(OPC_EXCH_DIGIT, 8'h00);
    chk(acc, 8'h35);
    chk({6'h00, status}, 8'h02);
    chk(psw_out, 8'h5a);
    run(OPC_XOR_A_DIR, 8'h20);
    chk(acc, 8'h43);
    run(OPC_XOR_A_IND, 8'h00);
    chk(acc, 8'h35);
    run(OPC_XOR_A_REG, 8'h00);
    chk(acc, 8'h15);
    run(OPC_EXCH_DIGIT | 8'h01, 8'h00);
    run(OPC_XOR_A_DIR, 8'h00);
    chk(acc, 8'h15);
  endtask : t_digit
  task print_verdict;
    $display("%0d checks, %0d errors", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : print_verdict
  initial
  begin
    repeat (2) @(negedge clk_sys);
    srst = 1'b0;
    t_acc;
    t_dest;
    t_digit;
    print_verdict;
  end
endmodule : nxu_core_tb
`default_nettype wire

// [verif/nxu_pins.sv]
// nxu_pins: port one pins, each loaded against its latch
`timescale 1ns/10ps
`default_nettype none
module nxu_pins (
  // port one
  input  wire logic [7:0] port1_latch,
  output wire logic [7:0] port1_pins
);
  assign port1_pins = ~port1_latch;
endmodule : nxu_pins
`default_nettype wire
